// *** verif/ext_sram_model.sv ***
// external sram stand-in that measures how long its strobes stay active
`timescale 1ns/1ps
`default_nettype none
module ext_sram_model
(
  // clock
  input wire logic i_clk_sys,
  // strobes from the decoder, active low
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  // cycles the current strobe run has lasted so far
  output logic [7:0] o_run
);
  // no data bus here: only the strobe timing is of interest
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rd_n || !i_wr_n)
      o_run <= o_run + 8'h01;
    else
      o_run <= 8'h00;
  end
endmodule
`default_nettype wire

// *** verif/test_data_space_access_decoder.sv ***
// self-checking bench for the data-space access decoder
`timescale 1ns/1ps
`default_nettype none
module test_data_space_access_decoder;
  import dsd_pkg::*;
  typedef struct {
    logic [4:0] sel;
    int n;
    logic err;
    logic [15:0] eff;
    logic wb;
    logic [15:0] wbv;
    logic [4:0] wbi;
    logic [1:0] stb;
  } exp_t;
  logic clk, srst, compat, xen, req, wr, stk, sh, use_ptr, nrd, nwr;
  logic [1:0] ws;
  logic [15:0] addr, pbase, ea;
  logic [5:0] io_addr, pdisp;
  ptr_sel_t psel;
  addr_mode_t pmode;
  logic rdy, done, err, wb_en, rd_n, wr_n, stall;
  logic [4:0] sel, wbi;
  logic [15:0] eff, wbv;
  logic [7:0] run;
  exp_t exp_q[$];
  exp_t e;
  int bad_count = 0;
  int num_checks = 0;
  int cnt = 100;
  int i, c, m;
  logic [15:0] tbl[10] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f,
    16'h0060, 16'h00ff, 16'h0100, 16'h0fff, 16'h10ff, 16'h1100};

  data_space_decoder dut (.i_clk_sys(clk), .i_srst(srst),
    .i_compat_mode(compat), .i_ext_mem_enable_bit(xen),
    .i_wait_states(ws), .i_acc_req(req), .i_acc_write(wr),
    .i_acc_stack_pc(stk), .i_acc_io_short(sh), .i_acc_use_ptr(use_ptr),
    .i_acc_addr(addr), .i_acc_io_addr(io_addr), .i_ptr_sel(psel),
    .i_ptr_mode(pmode), .i_ptr_base(pbase), .i_ptr_disp(pdisp),
    .i_nvm_read(nrd), .i_nvm_write(nwr), .o_acc_ready(rdy),
    .o_acc_done(done), .o_acc_error(err), .o_target_sel(sel),
    .o_eff_addr(eff), .o_ptr_wb_en(wb_en), .o_ptr_wb_index(wbi),
    .o_ptr_wb_value(wbv), .o_ext_read_strobe_pin_n(rd_n),
    .o_ext_write_strobe_pin_n(wr_n), .o_core_stall(stall));

  ext_sram_model sram (.i_clk_sys(clk), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .o_run(run));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ***************************************************************
  // checking helpers
  // ***************************************************************
  task chk(input string what, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, x, g);
    end
  endtask

  task give_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one access: a is the address the decoder should arrive at
  task acc(input logic [15:0] a, input logic cm, en, w, s, h,
    input logic [1:0] k, input logic pw, input logic [15:0] pv);
    exp_t x;
    int t;
    if (a < 16'h0020) t = 0;
    else if (a < 16'h0060) t = 1;
    else if (a < 16'h0100 && !cm) t = 2;
    else if (a < (cm ? 16'h1000 : 16'h1100)) t = 3;
    else t = 4;
    x.sel = 5'(1 << t);
    x.n = (t < 3) ? 1 : (t == 3 || !en) ? 2 : s ? 3 + 2 * (k + 1) : 3 + k;
    x.err = (t == 4) && !en;
    x.eff = a;
    x.wb = pw;
    x.wbv = pv;
    x.wbi = 5'(26 + 2 * int'(psel));
    x.stb = (t == 4 && en) ? (w ? 2'd2 : 2'd1) : 2'd0;
    exp_q.push_back(x);
    compat = cm;
    xen = en;
    wr = w;
    stk = s;
    sh = h;
    ws = k;
    io_addr = 6'(a - 16'h0020);
    // short form and pointer forms must ignore the direct address
    addr = (h || use_ptr) ? 16'h0080 : a;
    req = 1'b1;
    for (t = 0; t < 60; t++)
    begin
      @(posedge clk);
      if (rdy === 1'b1)
        break;
    end
    #1 req = 1'b0;
    chk("take wait", 16'h0000, 16'(t == 60));
    for (t = 0; t < 60; t++)
    begin
      @(posedge clk);
      if (rdy === 1'b1)
        break;
    end
    chk("done wait", 16'h0000, 16'(t == 60));
    #1;
  endtask

  task nvm(input logic r, input int len);
    int k;
    k = 0;
    nrd = r;
    nwr = !r;
    @(posedge clk);
    #1 nrd = 1'b0;
    nwr = 1'b0;
    repeat (12)
    begin
      @(posedge clk);
      if (stall === 1'b1)
      begin
        k++;
        chk("ready while stalled", 16'h0000, 16'(rdy));
      end
    end
    chk("stall cycles", 16'(len), 16'(k));
    #1;
  endtask

  // ***************************************************************
  // result monitor
  // ***************************************************************
  always @(posedge clk)
  begin
    if (exp_q.size() > 0 && cnt == 1)
    begin
      e = exp_q[0];
      chk("eff_addr", e.eff, eff);
      chk("wb_en", 16'(e.wb), 16'(wb_en));
      if (e.wb)
      begin
        chk("wb_index", 16'(e.wbi), 16'(wbi));
        chk("wb_value", e.wbv, wbv);
      end
    end
    if (done === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk("target", 16'(e.sel), 16'(sel));
      chk("cycles", 16'(e.n), 16'(cnt));
      chk("error", 16'(e.err), 16'(err));
      chk("rd strobe", 16'(e.stb != 2'd1), 16'(rd_n));
      chk("wr strobe", 16'(e.stb != 2'd2), 16'(wr_n));
      if (e.stb != 2'd0)
        chk("strobe run", 16'(e.n - 1), 16'(run));
    end
    cnt++;
    if (req === 1'b1 && rdy === 1'b1)
      cnt = 1;
  end

  initial
  begin
    #200000;
    bad_count++;
    give_verdict;
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    {srst, compat, xen, req, wr, stk, sh, use_ptr, nrd, nwr} = 10'h200;
    ws = 2'b00;
    addr = 16'h0000;
    io_addr = 6'h00;
    psel = PTR_X;
    pmode = AM_PLAIN;
    pbase = 16'h0000;
    pdisp = 6'h00;
    void'($urandom(57));
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    chk("reset target", 16'h0001, 16'(sel));
    chk("reset strobes", 16'h0003, 16'({rd_n, wr_n}));
    for (c = 0; c < 2; c++)
      for (i = 0; i < 10; i++)
        acc(tbl[i], c[0], 1'b1, 1'($urandom_range(1)), 1'b0, 1'b0,
          2'($urandom_range(3)), 1'b0, 16'h0000);
    for (i = 0; i < 8; i++)
    begin
      acc(16'h1100 + 16'($urandom_range(16'hee00)), 1'b0, 1'b1, i[2],
        1'b0, 1'b0, 2'(i), 1'b0, 16'h0000);
      acc(16'hffff, i[2], 1'b1, i[0], 1'b1, 1'b0, 2'(i),
        1'b0, 16'h0000);
      acc(16'h4000, i[0], 1'b0, i[1], 1'b0, 1'b0, 2'(i),
        1'b0, 16'h0000);
      acc(16'h0020 + 16'($urandom_range(63)), i[0], 1'b1, i[1], 1'b0,
        1'b1, 2'b00, 1'b0, 16'h0000);
    end
    use_ptr = 1'b1;
    for (m = 0; m < 12; m++)
    begin
      pmode = addr_mode_t'(m % 4);
      // displacement alternates y and z so both bases are exercised
      psel = ptr_sel_t'((m % 4 == 1) ? 1 + (m / 4) % 2 : m % 3);
      pbase = 16'h0200 + 16'($urandom_range(3000));
      pdisp = (m < 4) ? 6'h3f : 6'($urandom_range(63));
      ea = (m % 4 == 1) ? pbase + 16'(pdisp) :
        (m % 4 == 2) ? pbase - 16'h0001 : pbase;
      acc(ea, 1'b0, 1'b1, m[0], 1'b0, 1'b0, 2'b00, m[1],
        (m % 4 == 2) ? ea : pbase + 16'h0001);
    end
    use_ptr = 1'b0;
    nvm(1'b1, 4);
    nvm(1'b0, 2);
    repeat (3) @(posedge clk);
    chk("pending results", 16'h0000, 16'(exp_q.size()));
    give_verdict;
  end
endmodule
`default_nettype wire

// *** verilog/data_space_decoder.sv ***
// data-space address decoder with access timing and core stall
//
// Notes on behaviour
// [RQ1] normal layout: 32 regs, 64 io, 160 xio, 4096 sram
// [RQ2] legacy layout: 32 regs, 64 io, 4000 sram
// [RQ3] legacy layout never selects extended io
// [RQ4] above internal region goes external, 64k space
// [RQ5] short io form reaches standard io only
// [RQ6] external access only with enable bit set
// [RQ7] strobes inactive during internal accesses
// [RQ8] external byte costs one extra cycle
// [RQ9] wait states 1-3 cost two to four extra
// [RQ10] stacked pc external costs 3,5,7,9 extra
// [RQ11] internal sram access takes two cycles
// [RQ12] displacement from y or z, up to 63
// [RQ13] pre-decrement before use, post-increment after
// [RQ14] stall four after nvm read, two after write
// [RQ15] exactly one target select per access
`timescale 1ns/1ps
`default_nettype none
module data_space_decoder
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // layout and external memory setup
  input wire logic i_compat_mode,
  input wire logic i_ext_mem_enable_bit,
  input wire logic [1:0] i_wait_states,
  // access request
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic i_acc_stack_pc,
  input wire logic i_acc_io_short,
  input wire logic i_acc_use_ptr,
  input wire logic [15:0] i_acc_addr,
  input wire logic [5:0] i_acc_io_addr,
  // pointer addressing
  input wire dsd_pkg::ptr_sel_t i_ptr_sel,
  input wire dsd_pkg::addr_mode_t i_ptr_mode,
  input wire logic [15:0] i_ptr_base,
  input wire logic [5:0] i_ptr_disp,
  // nonvolatile data memory events
  input wire logic i_nvm_read,
  input wire logic i_nvm_write,
  // access answer
  output logic o_acc_ready,
  output logic o_acc_done,
  output logic o_acc_error,
  output logic [4:0] o_target_sel,
  output logic [15:0] o_eff_addr,
  // pointer writeback
  output logic o_ptr_wb_en,
  output logic [4:0] o_ptr_wb_index,
  output logic [15:0] o_ptr_wb_value,
  // external memory strobes, active low
  output logic o_ext_read_strobe_pin_n,
  output logic o_ext_write_strobe_pin_n,
  // core stall
  output logic o_core_stall
);
  import dsd_pkg::*;

  // ***************************************************************
  // pointer address generation
  // ***************************************************************
  ptr_if pif ();

  assign pif.sel = i_ptr_sel;
  assign pif.mode = i_ptr_mode;
  assign pif.base = i_ptr_base;
  assign pif.disp = i_ptr_disp;

  ptr_addr_gen u_ptr_gen
  (
    .p (pif.gen)
  );

  // ***************************************************************
  // address decode and cost
  // ***************************************************************
  logic [15:0] dec_addr;
  logic [2:0] dec_tgt;
  logic [3:0] dec_cyc;
  logic [3:0] ext_extra;
  logic dec_err;
  logic [15:0] sram_end;

  always_comb
  begin
    sram_end = i_compat_mode ? SRAM_END_LEGACY : SRAM_END_NORMAL;
    dec_addr = i_acc_addr;
    if (i_acc_io_short)
    begin
      dec_addr = {10'h000, i_acc_io_addr} + IO_SHORT_OFFSET;
    end
    else if (i_acc_use_ptr)
    begin
      dec_addr = pif.eff_addr;
    end
    // one target always wins; regions are tested bottom up
    if (i_acc_io_short)
    begin
      dec_tgt = SEL_STDIO; // [RQ5]
    end
    else if (dec_addr < REGF_END)
    begin
      dec_tgt = SEL_REGF; // [RQ1] [RQ2]
    end
    else if (dec_addr < STDIO_END)
    begin
      dec_tgt = SEL_STDIO;
    end
    else if (!i_compat_mode && dec_addr < XIO_END)
    begin
      dec_tgt = SEL_XIO; // [RQ3]
    end
    else if (dec_addr < sram_end)
    begin
      dec_tgt = SEL_SRAM;
    end
    else
    begin
      dec_tgt = SEL_EXT; // [RQ4]
    end
    ext_extra = {2'b00, i_wait_states} + EXT_BYTE_EXTRA_NOWS; // [RQ8] [RQ9]
    dec_err = 1'b0;
    if (dec_tgt == SEL_REGF || dec_tgt == SEL_STDIO || dec_tgt == SEL_XIO)
    begin
      dec_cyc = CYC_REG_ACCESS;
    end
    else if (dec_tgt == SEL_SRAM)
    begin
      dec_cyc = CYC_MEM_ACCESS; // [RQ11]
    end
    else if (!i_ext_mem_enable_bit)
    begin
      // disabled space is not folded onto internal sram; flagged only
      dec_cyc = CYC_MEM_ACCESS;
      dec_err = 1'b1;
    end
    else if (i_acc_stack_pc)
    begin
      dec_cyc = CYC_MEM_ACCESS + (ext_extra << 1) + STACK_PIPE_LOSS; // [RQ10]
    end
    else
    begin
      dec_cyc = CYC_MEM_ACCESS + ext_extra;
    end
  end

  // ***************************************************************
  // access sequencer
  // ***************************************************************
  acc_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [4:0] sel_q, sel_d;
  logic [15:0] addr_q, addr_d;
  logic err_q, err_d;
  logic rd_n_q, rd_n_d;
  logic wr_n_q, wr_n_d;
  logic wb_en_q, wb_en_d;
  logic [4:0] wb_idx_q, wb_idx_d;
  logic [15:0] wb_val_q, wb_val_d;
  logic acc_take;
  logic last_cyc;
  logic [2:0] stall_q, stall_d;

  assign o_acc_ready = (state_q == ST_IDLE) && (stall_q == 3'h0);
  assign acc_take = i_acc_req && o_acc_ready;
  assign last_cyc = (state_q == ST_BUSY) && (cnt_q == 4'h0);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    addr_d = addr_q;
    err_d = err_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    wb_en_d = 1'b0;
    wb_idx_d = wb_idx_q;
    wb_val_d = wb_val_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (acc_take)
        begin
          state_d = ST_BUSY;
          cnt_d = dec_cyc - 4'h1;
          sel_d = '0;
          sel_d[dec_tgt] = 1'b1; // [RQ15]
          addr_d = dec_addr;
          err_d = dec_err;
          // strobes move only for enabled external targets
          rd_n_d = !(dec_tgt == SEL_EXT && i_ext_mem_enable_bit &&
            !i_acc_write); // [RQ6] [RQ7]
          wr_n_d = !(dec_tgt == SEL_EXT && i_ext_mem_enable_bit &&
            i_acc_write);
          wb_en_d = i_acc_use_ptr && !i_acc_io_short && pif.wb_en; // [RQ13]
          wb_idx_d = pif.wb_index;
          wb_val_d = pif.wb_val;
        end
      end
      ST_BUSY:
      begin
        cnt_d = cnt_q - 4'h1;
        if (last_cyc)
        begin
          state_d = ST_IDLE;
          cnt_d = 4'h0;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sel_q <= 5'h01;
      addr_q <= 16'h0000;
      err_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      wb_en_q <= 1'b0;
      wb_idx_q <= 5'h00;
      wb_val_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      addr_q <= addr_d;
      err_q <= err_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      wb_en_q <= wb_en_d;
      wb_idx_q <= wb_idx_d;
      wb_val_q <= wb_val_d;
    end
  end

  assign o_acc_done = last_cyc;
  assign o_acc_error = last_cyc && err_q;
  assign o_target_sel = sel_q;
  assign o_eff_addr = addr_q;
  assign o_ptr_wb_en = wb_en_q;
  assign o_ptr_wb_index = wb_idx_q;
  assign o_ptr_wb_value = wb_val_q;
  assign o_ext_read_strobe_pin_n = rd_n_q;
  assign o_ext_write_strobe_pin_n = wr_n_q;

  // ***************************************************************
  // nonvolatile access stall
  // ***************************************************************
  always_comb
  begin
    stall_d = stall_q;
    if (i_nvm_read)
    begin
      stall_d = NVM_RD_STALL; // [RQ14]
    end
    else if (i_nvm_write)
    begin
      stall_d = NVM_WR_STALL; // [RQ14]
    end
    else if (stall_q != 3'h0)
    begin
      stall_d = stall_q - 3'h1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      stall_q <= 3'h0;
    end
    else
    begin
      stall_q <= stall_d;
    end
  end

  assign o_core_stall = (stall_q != 3'h0);

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  a_sel_one_hot: assert property ($onehot(o_target_sel)) // [RQ15]
    else $error("target select not one-hot");
  a_int_strobes_quiet: assert property ( // [RQ7]
    (state_q == ST_BUSY && !o_target_sel[SEL_EXT]) |->
    (o_ext_read_strobe_pin_n && o_ext_write_strobe_pin_n))
    else $error("strobe active on internal access");
  a_strobe_needs_enable: assert property ( // [RQ6]
    (acc_take && dec_tgt == SEL_EXT && !i_ext_mem_enable_bit) |=>
    (o_ext_read_strobe_pin_n && o_ext_write_strobe_pin_n) [*2])
    else $error("strobe with external memory disabled");
  a_sram_two_cycles: assert property ( // [RQ11]
    (acc_take && dec_tgt == SEL_SRAM) |=> !o_acc_done ##1 o_acc_done)
    else $error("internal sram access not two cycles");
  a_ext_no_wait: assert property ( // [RQ8]
    (acc_take && dec_tgt == SEL_EXT && i_ext_mem_enable_bit &&
    i_wait_states == 2'h0 && !i_acc_stack_pc) |=>
    !o_acc_done [*2] ##1 o_acc_done)
    else $error("external access without wait not three cycles");
  a_ext_three_wait: assert property ( // [RQ9]
    (acc_take && dec_tgt == SEL_EXT && i_ext_mem_enable_bit &&
    i_wait_states == 2'h3 && !i_acc_stack_pc) |=>
    !o_acc_done [*5] ##1 o_acc_done)
    else $error("external access with three waits not six cycles");
  a_stack_two_wait: assert property ( // [RQ10]
    (acc_take && dec_tgt == SEL_EXT && i_ext_mem_enable_bit &&
    i_wait_states == 2'h2 && i_acc_stack_pc) |=>
    !o_acc_done [*8] ##1 o_acc_done)
    else $error("stacked pc with two waits not nine cycles");
  a_legacy_no_xio: assert property ( // [RQ3]
    (acc_take && i_compat_mode && !i_acc_io_short &&
    dec_addr >= STDIO_END && dec_addr < XIO_END) |=>
    o_target_sel[SEL_SRAM])
    else $error("legacy layout decoded extended io");
  a_normal_xio: assert property ( // [RQ1]
    (acc_take && !i_compat_mode && !i_acc_io_short &&
    dec_addr >= STDIO_END && dec_addr < XIO_END) |=>
    o_target_sel[SEL_XIO])
    else $error("normal layout missed extended io");
  a_ext_boundary: assert property ( // [RQ4]
    (acc_take && !i_acc_io_short && dec_addr == sram_end) |=>
    o_target_sel[SEL_EXT])
    else $error("first address past internal not external");
  a_short_io_std: assert property ( // [RQ5]
    (acc_take && i_acc_io_short) |=> o_target_sel[SEL_STDIO])
    else $error("short io form left standard io");
  a_nvm_read_stall: assert property ( // [RQ14]
    (i_nvm_read && !i_nvm_write) |=> o_core_stall [*4] ##1
    (!o_core_stall || $past(i_nvm_read) || $past(i_nvm_write)))
    else $error("nvm read stall not four cycles");
  a_predec_addr: assert property ( // [RQ13]
    (acc_take && i_acc_use_ptr && !i_acc_io_short &&
    i_ptr_mode == AM_PREDEC) |=>
    o_eff_addr == $past(i_ptr_base) - 16'h0001 && o_ptr_wb_en)
    else $error("pre-decrement address wrong");
  a_disp_addr: assert property ( // [RQ12]
    (acc_take && i_acc_use_ptr && !i_acc_io_short &&
    i_ptr_mode == AM_DISP && i_ptr_sel != PTR_X) |=>
    o_eff_addr == $past(i_ptr_base) + {10'h000, $past(i_ptr_disp)})
    else $error("displacement address wrong");

  c_sram_access: cover property (acc_take && dec_tgt == SEL_SRAM);
  c_ext_read: cover property (!o_ext_read_strobe_pin_n ##1 o_acc_done);
  c_stack_ext: cover property (acc_take && i_acc_stack_pc &&
    dec_tgt == SEL_EXT && i_ext_mem_enable_bit);
  c_nvm_stall: cover property (i_nvm_write ##1 o_core_stall);

endmodule
`default_nettype wire

// *** verilog/dsd_pkg.sv ***
// shared constants and types for the data-space access decoder
package dsd_pkg;

  // ***************************************************************
  // region boundaries (first address past each region)
  // ***************************************************************
  localparam logic [15:0] REGF_END = 16'h0020;
  localparam logic [15:0] STDIO_END = 16'h0060;
  localparam logic [15:0] XIO_END = 16'h0100;
  localparam logic [15:0] SRAM_END_NORMAL = 16'h1100;
  localparam logic [15:0] SRAM_END_LEGACY = 16'h1000;
  localparam logic [15:0] IO_SHORT_OFFSET = 16'h0020;

  // ***************************************************************
  // target select bit positions
  // ***************************************************************
  localparam int NUM_TGT = 5;
  localparam logic [2:0] SEL_REGF = 3'h0;
  localparam logic [2:0] SEL_STDIO = 3'h1;
  localparam logic [2:0] SEL_XIO = 3'h2;
  localparam logic [2:0] SEL_SRAM = 3'h3;
  localparam logic [2:0] SEL_EXT = 3'h4;

  // ***************************************************************
  // cycle costs
  // ***************************************************************
  localparam logic [3:0] CYC_REG_ACCESS = 4'h1;
  localparam logic [3:0] CYC_MEM_ACCESS = 4'h2;
  localparam logic [3:0] EXT_BYTE_EXTRA_NOWS = 4'h1;
  localparam logic [3:0] STACK_PIPE_LOSS = 4'h1;
  localparam logic [2:0] NVM_RD_STALL = 3'h4;
  localparam logic [2:0] NVM_WR_STALL = 3'h2;

  // ***************************************************************
  // pointer registers
  // ***************************************************************
  localparam logic [4:0] PTR_X_LOW_REG = 5'h1a;
  localparam logic [4:0] PTR_Y_LOW_REG = 5'h1c;
  localparam logic [4:0] PTR_Z_LOW_REG = 5'h1e;

  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } ptr_sel_t;

  typedef enum logic [1:0] {
    AM_PLAIN = 2'b00,
    AM_DISP = 2'b01,
    AM_PREDEC = 2'b10,
    AM_POSTINC = 2'b11
  } addr_mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } acc_state_t;

endpackage

// *** verilog/ptr_addr_gen.sv ***
// pointer register address generation
`timescale 1ns/1ps
`default_nettype none
module ptr_addr_gen
(
  ptr_if.gen p
);
  import dsd_pkg::*;

  always_comb
  begin
    p.eff_addr = p.base;
    p.wb_val = p.base;
    p.wb_en = 1'b0;
    unique case (p.mode)
      AM_PLAIN:
      begin
        p.eff_addr = p.base;
      end
      AM_DISP:
      begin
        // x has no displacement form: falls back to plain
        if (p.sel != PTR_X)
        begin
          p.eff_addr = p.base + {10'h000, p.disp}; // [RQ12]
        end
      end
      AM_PREDEC:
      begin
        p.eff_addr = p.base - 16'h0001; // [RQ13]
        p.wb_val = p.base - 16'h0001;
        p.wb_en = 1'b1;
      end
      AM_POSTINC:
      begin
        p.eff_addr = p.base;
        p.wb_val = p.base + 16'h0001; // [RQ13]
        p.wb_en = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    unique case (p.sel)
      PTR_X: p.wb_index = PTR_X_LOW_REG;
      PTR_Y: p.wb_index = PTR_Y_LOW_REG;
      PTR_Z: p.wb_index = PTR_Z_LOW_REG;
      default: p.wb_index = PTR_Z_LOW_REG;
    endcase
  end

endmodule
`default_nettype wire

// *** verilog/ptr_if.sv ***
// carrier between the decoder and its pointer address generator
`timescale 1ns/1ps
`default_nettype none
interface ptr_if;
  import dsd_pkg::*;
  ptr_sel_t sel;
  addr_mode_t mode;
  logic [15:0] base;
  logic [5:0] disp;
  logic [15:0] eff_addr;
  logic [15:0] wb_val;
  logic wb_en;
  logic [4:0] wb_index;
  modport gen (input sel, mode, base, disp,
    output eff_addr, wb_val, wb_en, wb_index);
  modport user (output sel, mode, base, disp,
    input eff_addr, wb_val, wb_en, wb_index);
endinterface
`default_nettype wire
